// *** rtl/ext_port_pkg.sv ***
// Constants and carrier types for the external memory expansion port.
// Assumes one core clock and a synchronous active-low reset.
// Functional notes
// - Address outputs keep their last value while no transfer runs.
// - Data bus is undriven while no transfer runs.
// - Reset floats address, data, selects, space, strobes and peripheral select.
// - Program select low only for external program references, timed with address.
// - Cycles without external bus drive both program and data select high.
// - Data select low only for data references; space output picks X or Y.
// - Select encoding fixed; reserved combinations never produced.
// - Development-mode vector fetch: program low, data high, space high.
// - Read: strobe low, data bus released, word captured at strobe release.
// - Strobes qualify address and selects; valid only while a strobe is low.
// - Write: strobe low with write data driven for the whole strobe.
// - Peripheral select low for Y data accesses from ffc0 to ffff.
// - Bus-needed low in cycles needing the port, high during reset.
// - With bus granted away, core keeps running while no access needed.
// - Access while not master stalls with bus-needed held low.
// - On request, after current access, float outputs then grant bus.
// - Bus strobe low from start to end of each external cycle.
// - Bus wait low during bus strobe extends the cycle.
// - Each space has a 4-bit field adding 0 to 15 wait states.
package ext_port_pkg;
  localparam int addr_w = 16;
  localparam int data_w = 24;
  localparam logic [15:0] io_base = 16'hffc0;
  // Timing field positions in the 16-bit bus timing control word
  localparam int x_field_lsb = 0;
  localparam int y_field_lsb = 4;
  localparam int p_field_lsb = 8;
  localparam int io_field_lsb = 12;
  localparam logic [15:0] timing_reset = 16'hffff;
  localparam logic [3:0] wait_zero = 4'h0;

  typedef enum logic [2:0] {
    space_x = 3'h0,
    space_y = 3'h1,
    space_p = 3'h2,
    space_vec = 3'h3
  } space_t;

  typedef struct packed {
    logic valid;
    logic write;
    space_t space;
    logic [15:0] addr;
    logic [23:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [23:0] data_out;
    logic data_oe;
    logic ctrl_oe;
    logic program_select_n;
    logic data_space_select_n;
    logic space_x_n;
    logic read_n;
    logic write_n;
    logic peripheral_space_select_n;
  } pins_t;
endpackage : ext_port_pkg

// *** rtl/wait_timer.sv ***
// Wait-state counter for one external bus cycle.
// Assumes load is a one-cycle pulse at the start of a cycle.
module wait_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [3:0] count,
  input wire logic bus_wait_n,
  // Status
  output logic done
);
  typedef struct packed {
    logic [3:0] left;
    logic busy;
  } wt_state_t;
  wt_state_t st;
  wt_state_t next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.left = count;
      next_st.busy = 1'b1;
    end else if (st.busy && bus_wait_n) begin
      if (st.left != ext_port_pkg::wait_zero) begin
        next_st.left = st.left - 4'h1;
      end else begin
        next_st.busy = 1'b0;
      end
    end
  end

  assign done = st.busy && (st.left == ext_port_pkg::wait_zero) && bus_wait_n;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : wait_timer

// *** rtl/external_memory_port.sv ***
// External memory expansion port: address, data, selects, strobes and bus sharing.
// Assumes the core holds a request stable until ack; inputs synchronous to core_clk.
module external_memory_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Core side
  input wire ext_port_pkg::core_req_t core_req,
  input wire logic dev_mode,
  input wire logic [15:0] bus_timing_control,
  output logic core_ack,
  output logic [23:0] core_rdata,
  // Memory pins
  output ext_port_pkg::pins_t pins,
  input wire logic [23:0] ext_data_in,
  // Arbitration pins
  input wire logic bus_request_n,
  input wire logic bus_wait_n,
  output logic bus_grant_n,
  output logic bus_strobe_n,
  output logic bus_needed_n
);
  typedef enum logic [4:0] {
    st_reset = 5'b00001,
    st_idle = 5'b00010,
    st_access = 5'b00100,
    st_release = 5'b01000,
    st_granted = 5'b10000
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    ext_port_pkg::pins_t pins;
    logic ack;
    logic [23:0] rdata;
    logic grant_n;
    logic strobe_n;
    logic needed_n;
  } state_t;

  state_t st;
  state_t next_st;
  logic load;
  logic done;

  function automatic logic [3:0] wait_for(input ext_port_pkg::space_t s, input logic [15:0] a,
                                          input logic [15:0] t);
    if (s == ext_port_pkg::space_y && a >= ext_port_pkg::io_base) begin
      wait_for = t[ext_port_pkg::io_field_lsb +: 4];
    end else if (s == ext_port_pkg::space_y) begin
      wait_for = t[ext_port_pkg::y_field_lsb +: 4];
    end else if (s == ext_port_pkg::space_x) begin
      wait_for = t[ext_port_pkg::x_field_lsb +: 4];
    end else begin
      wait_for = t[ext_port_pkg::p_field_lsb +: 4];
    end
  endfunction : wait_for

  wait_timer u_wait (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(load),
    .count(wait_for(core_req.space, core_req.addr, bus_timing_control)),
    .bus_wait_n(bus_wait_n),
    .done(done)
  );

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    load = 1'b0;
    // needed when a request is pending and not being acknowledged
    next_st.needed_n = !(core_req.valid && !st.ack);
    case (st.fsm)
      st_reset: begin
        next_st.fsm = st_idle;
        next_st.pins.ctrl_oe = 1'b1;
        next_st.pins.program_select_n = 1'b1;
        next_st.pins.data_space_select_n = 1'b1;
        next_st.pins.space_x_n = 1'b0;
        next_st.pins.read_n = 1'b1;
        next_st.pins.write_n = 1'b1;
        next_st.pins.peripheral_space_select_n = 1'b1;
        next_st.needed_n = 1'b1;
      end
      st_idle: begin
        // selects high when bus unused; address held
        next_st.pins.program_select_n = 1'b1;
        next_st.pins.data_space_select_n = 1'b1;
        next_st.pins.space_x_n = 1'b0;
        next_st.pins.peripheral_space_select_n = 1'b1;
        next_st.pins.data_oe = 1'b0;
        if (!bus_request_n) begin
          next_st.fsm = st_release;
          next_st.pins.ctrl_oe = 1'b0;
        end else if (core_req.valid && !st.ack) begin
          load = 1'b1;
          next_st.fsm = st_access;
          next_st.pins.addr = core_req.addr;
          case (core_req.space)
            ext_port_pkg::space_x: begin
              next_st.pins.data_space_select_n = 1'b0;
            end
            ext_port_pkg::space_y: begin
              next_st.pins.data_space_select_n = 1'b0;
              next_st.pins.space_x_n = 1'b1;
              next_st.pins.peripheral_space_select_n = !(core_req.addr >= ext_port_pkg::io_base);
            end
            ext_port_pkg::space_vec: begin
              next_st.pins.program_select_n = 1'b0;
              next_st.pins.space_x_n = dev_mode;
            end
            default: begin
              next_st.pins.program_select_n = 1'b0;
            end
          endcase
          next_st.strobe_n = 1'b0;
          // write drive; read releases bus; strobe qualifies
          next_st.pins.write_n = !core_req.write;
          next_st.pins.read_n = core_req.write;
          next_st.pins.data_oe = core_req.write;
          next_st.pins.data_out = core_req.wdata;
        end
      end
      st_access: begin
        if (done) begin
          if (!st.pins.read_n) begin
            next_st.rdata = ext_data_in;
          end
          next_st.ack = 1'b1;
          next_st.needed_n = 1'b1;
          next_st.fsm = st_idle;
          next_st.strobe_n = 1'b1;
          next_st.pins.read_n = 1'b1;
          next_st.pins.write_n = 1'b1;
          next_st.pins.data_oe = 1'b0;
          next_st.pins.program_select_n = 1'b1;
          next_st.pins.data_space_select_n = 1'b1;
          next_st.pins.space_x_n = 1'b0;
          next_st.pins.peripheral_space_select_n = 1'b1;
        end
      end
      st_release: begin
        next_st.grant_n = 1'b0;
        next_st.fsm = st_granted;
      end
      st_granted: begin
        // core stalls only on pending access, bus-needed stays low
        if (bus_request_n) begin
          next_st.grant_n = 1'b1;
          next_st.pins.ctrl_oe = 1'b1;
          next_st.fsm = st_idle;
        end
      end
      default: begin
        next_st.fsm = st_reset;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.fsm <= st_reset;
      st.grant_n <= 1'b1;
      st.strobe_n <= 1'b1;
      st.needed_n <= 1'b1;
      st.pins.program_select_n <= 1'b1;
      st.pins.data_space_select_n <= 1'b1;
      st.pins.read_n <= 1'b1;
      st.pins.write_n <= 1'b1;
      st.pins.peripheral_space_select_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pins = st.pins;
  assign core_ack = st.ack;
  assign core_rdata = st.rdata;
  assign bus_grant_n = st.grant_n;
  assign bus_strobe_n = st.strobe_n;
  assign bus_needed_n = st.needed_n;

  property p_reset_float;
    @(posedge core_clk) !rst_n |=> (!pins.ctrl_oe && !pins.data_oe && bus_needed_n);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("outputs not floated in reset");
  property p_idle_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (st.fsm == st_idle && next_st.fsm == st_idle) |=> (pins.addr == $past(pins.addr));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("address changed while idle");
  property p_data_float;
    @(posedge core_clk) disable iff (!rst_n) bus_strobe_n |-> !pins.data_oe;
  endproperty
  a_data_float: assert property (p_data_float) else $error("data driven outside cycle");
  property p_no_reserved;
    @(posedge core_clk) disable iff (!rst_n)
      pins.ctrl_oe |-> !(!pins.program_select_n && !pins.data_space_select_n);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved select code");
  property p_idle_code;
    @(posedge core_clk) disable iff (!rst_n)
      (pins.ctrl_oe && pins.program_select_n && pins.data_space_select_n) |-> !pins.space_x_n;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("reserved idle space code");
  property p_stall_needed;
    @(posedge core_clk) disable iff (!rst_n)
      (!bus_grant_n && core_req.valid) |=> !bus_needed_n;
  endproperty
  a_stall_needed: assert property (p_stall_needed) else $error("stall without bus needed");
  property p_idle_selects;
    @(posedge core_clk) disable iff (!rst_n)
      (pins.ctrl_oe && bus_strobe_n) |-> (pins.program_select_n && pins.data_space_select_n);
  endproperty
  a_idle_selects: assert property (p_idle_selects) else $error("select low when idle");
  property p_write_drive;
    @(posedge core_clk) disable iff (!rst_n) !pins.write_n |-> (pins.data_oe && !bus_strobe_n);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write without data");
  property p_read_release;
    @(posedge core_clk) disable iff (!rst_n) !pins.read_n |-> !pins.data_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("read with bus driven");
  property p_periph;
    @(posedge core_clk) disable iff (!rst_n)
      !pins.peripheral_space_select_n |-> (pins.addr >= ext_port_pkg::io_base && pins.space_x_n);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral select out of range");
  property p_grant_float;
    @(posedge core_clk) disable iff (!rst_n) !bus_grant_n |-> (!pins.ctrl_oe && bus_strobe_n);
  endproperty
  a_grant_float: assert property (p_grant_float) else $error("grant with outputs driven");
  property p_wait_stretch;
    @(posedge core_clk) disable iff (!rst_n)
      (!bus_strobe_n && !bus_wait_n) |=> !bus_strobe_n;
  endproperty
  a_wait_stretch: assert property (p_wait_stretch) else $error("cycle ended under wait");
  c_read: cover property (@(posedge core_clk) !pins.read_n ##[1:20] core_ack);
  c_write: cover property (@(posedge core_clk) !pins.write_n ##[1:20] core_ack);
  c_grant: cover property (@(posedge core_clk) !bus_grant_n ##1 !bus_needed_n);
endmodule : external_memory_port

// *** tb/ext_mem_model.sv ***
// Static memory model standing on the far side of the expansion port.
// Assumes pins change on core_clk; 16 words decoded from the low address bits.
module ext_mem_model (
  // Clock
  input wire logic core_clk,
  // Bus pins
  input wire ext_port_pkg::pins_t pins,
  output logic [23:0] ext_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] mem [16];
  logic [23:0] wbuf = 24'h0;
  logic [23:0] last = 24'h0;
  logic wr_q = 1'b1;
  logic [3:0] aq = 4'h0;
  always_comb begin
    if (pins.ctrl_oe && !pins.read_n) begin
      ext_data_in = mem[pins.addr[3:0]];
    end else if (pins.data_oe) begin
      ext_data_in = pins.data_out;
    end else begin
      ext_data_in = ~last;
    end
  end
  always @(posedge core_clk) begin
    if (!pins.write_n && pins.data_oe) begin
      wbuf <= pins.data_out;
    end
    if (!wr_q && pins.write_n) begin
      mem[aq] <= wbuf;
    end
    wr_q <= pins.write_n;
    aq <= pins.addr[3:0];
    last <= ext_data_in;
  end
endmodule : ext_mem_model

// *** tb/external_memory_port_test.sv ***
// Self-checking bench for the external memory expansion port.
// Assumes ext_mem_model answers on the pins; timing fields X 0, Y 1, P 2, I/O 3.
module external_memory_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ext_port_pkg::core_req_t core_req = '0;
  logic dev_mode = 1'b0;
  logic [15:0] bus_timing_control = 16'h3210;
  logic bus_request_n = 1'b1;
  logic bus_wait_n = 1'b1;
  logic core_ack, bus_grant_n, bus_strobe_n, bus_needed_n;
  logic [23:0] core_rdata, ext_data_in;
  ext_port_pkg::pins_t pins;
  int n_mismatch = 0;
  int total_checks = 0;
  external_memory_port uut (.core_clk(core_clk), .rst_n(rst_n), .core_req(core_req),
    .dev_mode(dev_mode), .bus_timing_control(bus_timing_control), .core_ack(core_ack),
    .core_rdata(core_rdata), .pins(pins), .ext_data_in(ext_data_in),
    .bus_request_n(bus_request_n), .bus_wait_n(bus_wait_n), .bus_grant_n(bus_grant_n),
    .bus_strobe_n(bus_strobe_n), .bus_needed_n(bus_needed_n));
  ext_mem_model model (.core_clk(core_clk), .pins(pins), .ext_data_in(ext_data_in));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step
  // One access; sel holds program, data, space and peripheral selects
  task automatic acc(input logic w, input ext_port_pkg::space_t s, input logic [15:0] a,
      input logic [23:0] d, input logic [3:0] sel, input int lat, input int wt);
    int n;
    int k;
    logic [3:0] got;
    logic [3:0] drv;
    step();
    core_req = '{valid: 1'b1, write: w, space: s, addr: a, wdata: d};
    n = 0;
    k = -1;
    while (core_ack !== 1'b1) begin
      step();
      n++;
      if (n > 40) begin
        n_mismatch++;
        complete_run();
      end
      if (bus_strobe_n === 1'b0 && k < 0) begin
        k = 0;
        got = {pins.program_select_n, pins.data_space_select_n, pins.space_x_n,
          pins.peripheral_space_select_n};
        drv = {pins.read_n, pins.write_n, pins.data_oe, bus_needed_n};
      end
      if (k >= 0 && core_ack !== 1'b1) begin
        bus_wait_n = (k >= wt);
        k++;
      end
    end
    core_req.valid = 1'b0;
    bus_wait_n = 1'b1;
    check(got, sel);
    check(drv, {w, ~w, w, 1'b0});
    check(n, lat + wt);
    if (!w) check(core_rdata, d);
    step();
    check({pins.addr, pins.data_oe, pins.program_select_n, pins.data_space_select_n},
      {a, 3'b011});
  endtask : acc
  // Bus handed away, access stalls until returned
  task automatic grant_test;
    int n;
    step();
    bus_request_n = 1'b0;
    n = 0;
    while (bus_grant_n !== 1'b0 && n < 10) begin
      step();
      n++;
    end
    check({n < 10, pins.ctrl_oe, pins.data_oe}, 3'b100);
    if (n >= 10) begin
      complete_run();
    end
    core_req = '{valid: 1'b1, write: 1'b0, space: ext_port_pkg::space_x, addr: 16'h0001,
      wdata: 24'h0};
    repeat (4) step();
    check({bus_needed_n, core_ack, bus_grant_n}, 3'b000);
    bus_request_n = 1'b1;
    n = 0;
    while (core_ack !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    core_req.valid = 1'b0;
    check({n < 20, core_rdata}, {1'b1, 24'ha5a5a5});
    if (n >= 20) begin
      complete_run();
    end
  endtask : grant_test
  initial begin
    repeat (5) step();
    check({pins.ctrl_oe, pins.data_oe, pins.read_n, pins.write_n, bus_strobe_n,
      bus_needed_n, bus_grant_n}, 7'h1f);
    rst_n = 1'b1;
    step();
    acc(1'b1, ext_port_pkg::space_x, 16'h0001, 24'ha5a5a5, 4'h9, 2, 0);
    acc(1'b0, ext_port_pkg::space_x, 16'h0001, 24'ha5a5a5, 4'h9, 2, 2);
    acc(1'b1, ext_port_pkg::space_y, 16'h0002, 24'h123456, 4'hb, 3, 0);
    acc(1'b0, ext_port_pkg::space_y, 16'h0002, 24'h123456, 4'hb, 3, 0);
    acc(1'b1, ext_port_pkg::space_y, 16'hffc3, 24'h0f0f0f, 4'ha, 5, 0);
    acc(1'b0, ext_port_pkg::space_y, 16'hffc3, 24'h0f0f0f, 4'ha, 5, 1);
    acc(1'b0, ext_port_pkg::space_p, 16'h0001, 24'ha5a5a5, 4'h5, 4, 0);
    acc(1'b0, ext_port_pkg::space_vec, 16'h0002, 24'h123456, 4'h5, 4, 0);
    dev_mode = 1'b1;
    acc(1'b0, ext_port_pkg::space_vec, 16'h0003, 24'h0f0f0f, 4'h7, 4, 0);
    grant_test();
    complete_run();
  end
endmodule : external_memory_port_test
